/* hdl/sdw_core.v */
// Mode register and masked write path of a separate-I/O DDR DRAM.
// Assumes commands synchronous to clk_i; write data clock sampled by clk_i.
`include "sdw_defines.vh"
`default_nettype none

module sdw_core #(
  parameter DW     = 18,
  parameter AW     = 20,
  parameter FDEPTH = 16,
  parameter CAL_PERIOD = `SDW_CAL_PERIOD
) (
  input  wire           clk_i,
  input  wire           rstn_i,
  input  wire           cs_n_i,
  input  wire           we_n_i,
  input  wire           ref_n_i,
  input  wire [AW-1:0]  addr_i,
  input  wire [2:0]     bank_i,
  input  wire           write_data_clock_i,
  input  wire [DW-1:0]  wdata_i,
  input  wire           write_mask_i,
  input  wire           read_burst_active_i,
  output reg  [`SDW_MODE_W-1:0] mode_o,
  output reg            mode_valid_o,
  output reg  [3:0]     read_latency_cycles_o,
  output reg  [3:0]     write_latency_cycles_o,
  output reg  [3:0]     burst_length_setting_o,
  output reg            dll_locked_o,
  output reg            mode_set_recovery_o,
  output reg            impedance_ext_o,
  output reg            impedance_cal_o,
  output reg            term_read_o,
  output reg            term_input_o,
  output reg            refresh_o,
  output reg  [2:0]     refresh_bank_o,
  output reg            read_cmd_o,
  output reg  [2:0]     read_bank_o,
  output reg  [AW-1:0]  read_addr_o,
  output reg            wr_overflow_o,
  output wire [DW+AW+2:0] store_data_o,
  output wire           store_valid_o,
  input  wire           store_ready_i
);

  // -----------------------------------------------------------------
  // Decoding helpers
  // -----------------------------------------------------------------
  function [3:0] rl_of;
    input [2:0] cfg;
    begin
      case (cfg)
        `SDW_CFG_ONE:   rl_of = `SDW_RL_CFG1;
        `SDW_CFG_TWO:   rl_of = `SDW_RL_CFG2;
        `SDW_CFG_THREE: rl_of = `SDW_RL_CFG3;
        default:        rl_of = `SDW_RL_CFG1;
      endcase
    end
  endfunction

  function [3:0] bl_of;
    input [1:0] sel;
    begin
      case (sel)
        `SDW_BL_TWO:   bl_of = 4'h2;
        `SDW_BL_FOUR:  bl_of = 4'h4;
        `SDW_BL_EIGHT: bl_of = 4'h8;
        default:       bl_of = 4'h2;
      endcase
    end
  endfunction

  // Keeps only the address bits that carry meaning for the burst length
  function [AW-1:0] addr_mask;
    input [AW-1:0] a;
    input [3:0]    bl;
    begin
      case (bl)
        4'h2:    addr_mask = a;
        4'h4:    addr_mask = {1'b0, a[AW-2:0]};
        default: addr_mask = {2'b00, a[AW-3:0]};
      endcase
    end
  endfunction

  localparam CMD_NONE  = 2'h0;
  localparam CMD_MODE  = 2'h1;
  localparam CMD_READ  = 2'h2;
  localparam CMD_WRITE = 2'h3;

  // -----------------------------------------------------------------
  // Command decode and multiplexed address assembly
  // -----------------------------------------------------------------
  reg [1:0]    cmd;
  wire         mux_mode = mode_valid_o & mode_o[`SDW_MUX_BIT];
  reg          pend_ff;
  reg [1:0]    pend_cmd_ff;
  reg [10:0]   pend_lo_ff;
  reg [2:0]    pend_bank_ff;
  reg          done;
  reg [1:0]    done_cmd;
  reg [AW-1:0] done_addr;
  reg [2:0]    done_bank;

  always @* begin
    cmd = CMD_NONE;
    if (!cs_n_i && !pend_ff) begin
      if (!we_n_i && !ref_n_i) cmd = CMD_MODE;
      else if (!we_n_i)        cmd = CMD_WRITE;
      else if (ref_n_i)        cmd = CMD_READ;
    end
  end

  always @* begin
    done      = 1'b0;
    done_cmd  = CMD_NONE;
    done_addr = {AW{1'b0}};
    done_bank = 3'h0;
    if (pend_ff) begin
      done      = 1'b1;
      done_cmd  = pend_cmd_ff;
      done_addr = {addr_i[AW-12:0], pend_lo_ff};
      done_bank = pend_bank_ff;
    end else if (!mux_mode && cmd != CMD_NONE) begin
      done      = 1'b1;
      done_cmd  = cmd;
      done_addr = addr_i;
      done_bank = bank_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_ff      <= 1'b0;
      pend_cmd_ff  <= CMD_NONE;
      pend_lo_ff   <= 11'h000;
      pend_bank_ff <= 3'h0;
    end else begin
      // Second edge follows only in multiplexed mode; commands there thus take two clocks
      pend_ff <= mux_mode && cmd != CMD_NONE;
      if (cmd != CMD_NONE) begin
        pend_cmd_ff  <= cmd;
        pend_lo_ff   <= addr_i[10:0];
        pend_bank_ff <= bank_i;
      end
    end
  end

  // -----------------------------------------------------------------
  // Mode register and derived settings
  // -----------------------------------------------------------------
  wire mode_hit = done && done_cmd == CMD_MODE;
  reg  [10:0] dll_cnt_ff;
  reg  [3:0]  mrsc_cnt_ff;
  reg  [15:0] cal_cnt_ff;
  wire [3:0]  nxt_rl = rl_of(done_addr[`SDW_CFG_MSB:`SDW_CFG_LSB]);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o                 <= `SDW_MODE_RESET;
      mode_valid_o           <= 1'b0;
      read_latency_cycles_o  <= `SDW_RL_CFG1;
      write_latency_cycles_o <= `SDW_RL_CFG1 + 4'h1;
      burst_length_setting_o <= 4'h2;
    end else if (mode_hit) begin
      // Bits 10..17 are expected low; stored as given
      mode_o                 <= done_addr[`SDW_MODE_W-1:0];
      mode_valid_o           <= 1'b1;
      read_latency_cycles_o  <= nxt_rl;
      write_latency_cycles_o <= nxt_rl + 4'h1;
      // Old data is not rebased when the burst length changes
      burst_length_setting_o <= bl_of(done_addr[`SDW_BL_MSB:`SDW_BL_LSB]);
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dll_cnt_ff          <= 11'h000;
      dll_locked_o        <= 1'b0;
      mrsc_cnt_ff         <= 4'h0;
      mode_set_recovery_o <= 1'b0;
      cal_cnt_ff          <= 16'h0000;
      impedance_cal_o     <= 1'b0;
      impedance_ext_o     <= 1'b0;
      term_read_o         <= 1'b0;
      term_input_o        <= 1'b0;
    end else begin
      // Clearing the enable bit restarts the lock wait
      if (!mode_o[`SDW_DLL_BIT] || !mode_valid_o) begin
        dll_cnt_ff   <= 11'h000;
        dll_locked_o <= 1'b0;
      end else if (dll_cnt_ff != `SDW_DLL_LOCK_CYCLES) begin
        dll_cnt_ff   <= dll_cnt_ff + 11'h001;
        dll_locked_o <= (dll_cnt_ff == `SDW_DLL_LOCK_CYCLES - 11'h001);
      end
      if (mode_hit) begin
        mrsc_cnt_ff         <= `SDW_MRSC_CYCLES;
        mode_set_recovery_o <= 1'b1;
      end else if (mrsc_cnt_ff != 4'h0) begin
        mrsc_cnt_ff         <= mrsc_cnt_ff - 4'h1;
        mode_set_recovery_o <= (mrsc_cnt_ff != 4'h1);
      end
      // Recalibration runs in the background and never stalls commands
      impedance_ext_o <= mode_o[`SDW_IMP_BIT];
      if (cal_cnt_ff == CAL_PERIOD[15:0] - 16'h0001) begin
        cal_cnt_ff      <= 16'h0000;
        impedance_cal_o <= mode_valid_o;
      end else begin
        cal_cnt_ff      <= cal_cnt_ff + 16'h0001;
        impedance_cal_o <= 1'b0;
      end
      term_input_o <= mode_valid_o & mode_o[`SDW_TERM_BIT];
      term_read_o  <= mode_valid_o & mode_o[`SDW_TERM_BIT] & ~read_burst_active_i;
    end
  end

  // -----------------------------------------------------------------
  // Refresh and read notification
  // -----------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      refresh_o      <= 1'b0;
      refresh_bank_o <= 3'h0;
      read_cmd_o     <= 1'b0;
      read_bank_o    <= 3'h0;
      read_addr_o    <= {AW{1'b0}};
    end else begin
      // Refresh is single-edge even in multiplexed mode
      refresh_o      <= !cs_n_i && we_n_i && !ref_n_i && !pend_ff;
      refresh_bank_o <= bank_i;
      read_cmd_o     <= done && done_cmd == CMD_READ && mode_valid_o;
      read_bank_o    <= done_bank;
      read_addr_o    <= addr_mask(done_addr, burst_length_setting_o);
    end
  end

  // -----------------------------------------------------------------
  // Write latency pipeline and address queue
  // -----------------------------------------------------------------
  // Latency counts from the first command edge, so the pipe is fed there
  wire         wr_first = mode_valid_o && cmd == CMD_WRITE;
  wire         wr_done  = mode_valid_o && done && done_cmd == CMD_WRITE;
  reg  [15:0]  wpipe_ff;
  reg  [AW+2:0] aq_ff [0:3];
  reg  [1:0]   aq_wr_ff;
  reg  [1:0]   aq_rd_ff;
  wire         win_start = wpipe_ff[write_latency_cycles_o - 4'h2];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wpipe_ff <= 16'h0000;
    end else begin
      wpipe_ff <= {wpipe_ff[14:0], wr_first};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_aq
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          aq_ff[g] <= {(AW+3){1'b0}};
        end else if (wr_done && aq_wr_ff == g) begin
          aq_ff[g] <= {done_bank, addr_mask(done_addr, burst_length_setting_o)};
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Data clock synchronisers and beat capture
  // -----------------------------------------------------------------
  reg          dk_s1_ff;
  reg          dk_s2_ff;
  reg          dk_s3_ff;
  reg [DW:0]   d_s1_ff;
  reg [DW:0]   d_s2_ff;
  wire         dk_rise = dk_s2_ff & ~dk_s3_ff;
  wire         dk_edge = dk_s2_ff ^ dk_s3_ff;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dk_s1_ff <= 1'b0;
      dk_s2_ff <= 1'b0;
      dk_s3_ff <= 1'b0;
      d_s1_ff  <= {(DW+1){1'b0}};
      d_s2_ff  <= {(DW+1){1'b0}};
    end else begin
      dk_s1_ff <= write_data_clock_i;
      dk_s2_ff <= dk_s1_ff;
      dk_s3_ff <= dk_s2_ff;
      d_s1_ff  <= {write_mask_i, wdata_i};
      d_s2_ff  <= d_s1_ff;
    end
  end

  localparam CAP_IDLE = 2'h0;
  localparam CAP_WAIT = 2'h1;
  localparam CAP_RUN  = 2'h2;

  reg  [1:0]     cap_ff;
  reg  [1:0]     nxt_cap;
  reg  [3:0]     beat_ff;
  reg  [AW+2:0]  cur_ff;
  wire           beat_take = (cap_ff == CAP_WAIT && dk_rise) || (cap_ff == CAP_RUN && dk_edge);
  wire [3:0]     beat_idx  = (cap_ff == CAP_WAIT) ? 4'h0 : beat_ff;
  wire           fifo_ready;
  // Masked beats never enter the store queue
  wire           fifo_push = beat_take & ~d_s2_ff[DW];
  wire [AW-1:0]  beat_addr = cur_ff[AW-1:0] + {{(AW-4){1'b0}}, beat_idx};

  always @* begin
    nxt_cap = cap_ff;
    case (cap_ff)
      CAP_IDLE: if (win_start) nxt_cap = CAP_WAIT;
      CAP_WAIT: if (dk_rise) nxt_cap = (burst_length_setting_o == 4'h1) ? CAP_IDLE : CAP_RUN;
      CAP_RUN:  if (dk_edge && beat_ff == burst_length_setting_o - 4'h1) nxt_cap = CAP_IDLE;
      default:  nxt_cap = CAP_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cap_ff        <= CAP_IDLE;
      beat_ff       <= 4'h0;
      cur_ff        <= {(AW+3){1'b0}};
      aq_wr_ff      <= 2'h0;
      aq_rd_ff      <= 2'h0;
      wr_overflow_o <= 1'b0;
    end else begin
      cap_ff <= nxt_cap;
      if (wr_done) begin
        aq_wr_ff <= aq_wr_ff + 2'h1;
      end
      if (cap_ff == CAP_IDLE && win_start) begin
        cur_ff   <= aq_ff[aq_rd_ff];
        aq_rd_ff <= aq_rd_ff + 2'h1;
      end
      if (beat_take) begin
        beat_ff <= beat_idx + 4'h1;
      end else if (cap_ff == CAP_IDLE) begin
        beat_ff <= 4'h0;
      end
      // A full queue cannot stall the controller, so the loss is flagged
      if (fifo_push && !fifo_ready) begin
        wr_overflow_o <= 1'b1;
      end
    end
  end

  sdw_fifo #(
    .WIDTH (DW + AW + 3),
    .DEPTH (FDEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_data_i   ({cur_ff[AW+2:AW], beat_addr, d_s2_ff[DW-1:0]}),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (store_data_o),
    .out_valid_o (store_valid_o),
    .out_ready_i (store_ready_i)
  );

endmodule // sdw_core

`default_nettype wire

/* hdl/sdw_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none

module sdw_fifo #(
  parameter WIDTH = 44,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= in_data_i;
        wr_ff         <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule // sdw_fifo

`default_nettype wire

/* include/sdw_defines.vh */
// Constants for the mode register and write path of the separate-I/O DDR DRAM model.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef SDW_DEFINES_VH
`define SDW_DEFINES_VH

// -----------------------------------------------------------------
// Mode register fields
// -----------------------------------------------------------------
`define SDW_MODE_W          18
`define SDW_MODE_RESET      18'h00000
`define SDW_CFG_LSB         0
`define SDW_CFG_MSB         2
`define SDW_BL_LSB          3
`define SDW_BL_MSB          4
`define SDW_MUX_BIT         5
`define SDW_DLL_BIT         7
`define SDW_IMP_BIT         8
`define SDW_TERM_BIT        9

// -----------------------------------------------------------------
// Encodings
// -----------------------------------------------------------------
`define SDW_CFG_ONE         3'h0
`define SDW_CFG_TWO         3'h1
`define SDW_CFG_THREE       3'h2
`define SDW_BL_TWO          2'h0
`define SDW_BL_FOUR         2'h1
`define SDW_BL_EIGHT        2'h2
`define SDW_RL_CFG1         4'h4
`define SDW_RL_CFG2         4'h6
`define SDW_RL_CFG3         4'h8

// -----------------------------------------------------------------
// Timing counts, in command clock cycles
// -----------------------------------------------------------------
`define SDW_DLL_LOCK_CYCLES 11'h400
`define SDW_MRSC_CYCLES     4'h6
`define SDW_CAL_PERIOD      16'h1000

`endif

/* tb/sdw_core_bench.sv */
// Self-checking bench for sdw_core: mode sets, commands, masked writes.
// Assumes sdw_dk_model as write data source and a 100 MHz command clock.
`default_nettype none
module sdw_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rstn_i, cs_n_i, we_n_i, ref_n_i, rba_i, srdy_i, go, dk, wm, mbusy;
  logic [19:0] addr_i;
  logic [2:0]  bank_i;
  logic [3:0]  beats;
  logic [17:0] base, wd;
  logic [7:0]  msk;
  wire  [17:0] mode;
  wire  [3:0]  rl, wl, bl;
  wire  [2:0]  rfb, rdb;
  wire  [19:0] ra;
  wire  [40:0] sd;
  wire         mv, dll, rec, iext, ical, trd, tin, rf, rc, ovf, sv;
  int fail_count, checked, cyc;
  sdw_core #(.CAL_PERIOD(16)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
    .we_n_i(we_n_i), .ref_n_i(ref_n_i), .addr_i(addr_i), .bank_i(bank_i),
    .write_data_clock_i(dk), .wdata_i(wd), .write_mask_i(wm), .read_burst_active_i(rba_i),
    .mode_o(mode), .mode_valid_o(mv), .read_latency_cycles_o(rl),
    .write_latency_cycles_o(wl), .burst_length_setting_o(bl), .dll_locked_o(dll),
    .mode_set_recovery_o(rec), .impedance_ext_o(iext), .impedance_cal_o(ical),
    .term_read_o(trd), .term_input_o(tin), .refresh_o(rf), .refresh_bank_o(rfb),
    .read_cmd_o(rc), .read_bank_o(rdb), .read_addr_o(ra), .wr_overflow_o(ovf),
    .store_data_o(sd), .store_valid_o(sv), .store_ready_i(srdy_i));
  sdw_dk_model u_ctrl (.go_i(go), .beats_i(beats), .base_i(base), .mask_i(msk),
    .dk_o(dk), .d_o(wd), .m_o(wm), .busy_o(mbusy));
  // -----------------------------------------
  // Shared tasks
  // -----------------------------------------
  task automatic chk(input string n, input logic [40:0] e, input logic [40:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic w, input logic r, input logic [19:0] a, input logic [2:0] b);
    @(negedge clk_i);
    {cs_n_i, we_n_i, ref_n_i, addr_i, bank_i} = {1'b0, w, r, a, b};
    @(negedge clk_i);
    {cs_n_i, addr_i} = {1'b1, ~a};
  endtask
  // Bits 10..17 kept zero; next command only after recovery
  task automatic mset(input logic [19:0] a);
    cmd(1'b0, 1'b0, a, 3'h0);
    repeat (7) @(negedge clk_i);
  endtask
  task automatic wr(input logic [2:0] b, input logic [19:0] a, input logic [17:0] d,
                    input logic [7:0] m);
    int k;
    cmd(1'b0, 1'b1, a, b);
    repeat (6) @(negedge clk_i);
    {beats, base, msk, go} = {4'h8, d, m, 1'b1};
    @(negedge clk_i);
    go = 1'b0;
    for (k = 0; k < 100 && mbusy; k++) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task automatic t_init();
    cmd(1'b1, 1'b1, 20'h00010, 3'h1);
    @(negedge clk_i);
    chk("read_before_mode", 0, rc);
    chk("reset_latencies", {4'h4, 4'h5, 4'h2}, {rl, wl, bl});
    @(negedge clk_i);
    {cs_n_i, we_n_i, ref_n_i, addr_i} = {3'b000, 20'h00000};
    repeat (2) @(negedge clk_i);
    addr_i = 20'h00201;
    @(negedge clk_i);
    cs_n_i = 1'b1;
    @(negedge clk_i);
    chk("mode", {1'b1, 18'h00201}, {mv, mode});
    chk("lat_cfg2", {4'h6, 4'h7, 4'h2, 1'b1}, {rl, wl, bl, rec});
    repeat (6) @(negedge clk_i);
    chk("recovery_end", 0, rec);
    $display("Test init done");
  endtask
  task automatic t_cfg();
    logic [19:0] a [3] = '{20'h00008, 20'h00011, 20'h00302};
    logic [19:0] m [3] = '{20'h7ffff, 20'h3ffff, 20'hfffff};
    logic [3:0] l [3] = '{4'h4, 4'h6, 4'h8};
    logic [3:0] b [3] = '{4'h4, 4'h8, 4'h2};
    int i;
    // Burst eight never paired with the first configuration
    for (i = 0; i < 3; i++) begin
      mset(a[i]);
      chk("rl_wl_bl", {l[i], l[i] + 4'h1, b[i]}, {rl, wl, bl});
      chk("imp_src", a[i][8], iext);
      cmd(1'b1, 1'b1, 20'hfffff, i[2:0] + 3'h1);
      chk("read", {1'b1, i[2:0] + 3'h1, m[i]}, {rc, rdb, ra});
    end
    $display("Test cfg done");
  endtask
  task automatic t_term();
    int k;
    rba_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("term_busy", 2'b10, {tin, trd});
    rba_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("term_idle", 2'b11, {tin, trd});
    for (k = 0; k < 40 && ical !== 1'b1; k++) @(negedge clk_i);
    chk("recal", 1, ical);
    $display("Test term done");
  endtask
  task automatic t_ref();
    @(negedge clk_i);
    {cs_n_i, we_n_i, ref_n_i, bank_i} = {3'b010, 3'h1};
    @(negedge clk_i);
    chk("ref1", {1'b1, 3'h1}, {rf, rfb});
    bank_i = 3'h6;
    @(negedge clk_i);
    cs_n_i = 1'b1;
    chk("ref2", {1'b1, 3'h6}, {rf, rfb});
    @(negedge clk_i);
    chk("ref_end", 0, rf);
    $display("Test ref done");
  endtask
  task automatic t_mux();
    mset(20'h00028);
    @(negedge clk_i);
    {cs_n_i, we_n_i, ref_n_i, addr_i, bank_i} = {3'b011, 20'h00123, 3'h5};
    @(negedge clk_i);
    {cs_n_i, addr_i} = {1'b1, 20'h00055};
    @(negedge clk_i);
    chk("mux_read", {1'b1, 3'h5, 20'h2a923}, {rc, rdb, ra});
    cmd(1'b1, 1'b0, 20'h00000, 3'h4);
    chk("mux_ref", {1'b1, 3'h4}, {rf, rfb});
    @(negedge clk_i);
    {cs_n_i, we_n_i, ref_n_i, addr_i} = {3'b000, 20'h00000};
    @(negedge clk_i);
    cs_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("mux_off", 0, mode);
    $display("Test mux done");
  endtask
  task automatic t_write();
    logic [19:0] ii;
    int k, j;
    mset(20'h00011);
    wr(3'h2, 20'h00040, 18'h01000, 8'h04);
    wr(3'h3, 20'h00080, 18'h02000, 8'h00);
    chk("no_overflow", 0, ovf);
    wr(3'h4, 20'h000c0, 18'h03000, 8'h00);
    chk("overflow", 2'b11, {ovf, sv});
    k = 0;
    for (j = 0; j < 40; j++) begin
      @(negedge clk_i);
      if (sv === 1'b1) begin
        ii = (k < 2) ? k : k + 1;
        if (k < 7) chk("store", {3'h2, 20'h00040 + ii, 18'h01000 + ii[17:0]}, sd);
        k++;
      end
      srdy_i = 1'b1;
    end
    chk("fifo_count", 16, k);
    $display("Test write done");
  endtask
  task automatic t_dll();
    int k;
    mset(20'h00080);
    repeat (990) @(negedge clk_i);
    chk("dll_early", 0, dll);
    for (k = 0; k < 60 && dll !== 1'b1; k++) @(negedge clk_i);
    chk("dll_lock", 1, dll);
    $display("Test dll done");
  endtask
  // -----------------------------------------
  // Clock, reset, sequence
  // -----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("Run took too long");
      wrap_up();
    end
  end
  initial begin
    {rstn_i, cs_n_i, we_n_i, ref_n_i, rba_i, srdy_i, go} = 7'b0111000;
    {addr_i, bank_i, beats, base, msk} = '0;
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    t_init();
    t_cfg();
    t_term();
    t_ref();
    t_mux();
    t_write();
    t_dll();
    wrap_up();
  end
endmodule  // sdw_core_bench
`default_nettype wire

/* tb/sdw_core_props.sv */
// Checker on the ports of sdw_core: mode register, latencies, commands.
// Assumes one command clock domain and an active-low async reset.
`default_nettype none
module sdw_core_props (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        cs_n_i,
  input wire logic        we_n_i,
  input wire logic        ref_n_i,
  input wire logic [19:0] addr_i,
  input wire logic [2:0]  bank_i,
  input wire logic        read_burst_active_i,
  input wire logic [17:0] mode_o,
  input wire logic        mode_valid_o,
  input wire logic [3:0]  read_latency_cycles_o,
  input wire logic [3:0]  write_latency_cycles_o,
  input wire logic [3:0]  burst_length_setting_o,
  input wire logic        dll_locked_o,
  input wire logic        mode_set_recovery_o,
  input wire logic        impedance_ext_o,
  input wire logic        term_read_o,
  input wire logic        term_input_o,
  input wire logic        refresh_o,
  input wire logic [2:0]  refresh_bank_o,
  input wire logic        read_cmd_o,
  input wire logic [19:0] read_addr_o
);
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Only single-edge (nonmultiplexed) commands are judged here
  wire md = !cs_n_i && !we_n_i && !ref_n_i && !mode_o[5];
  wire rf = !cs_n_i && we_n_i && !ref_n_i && !mode_o[5];
  wire rd = !cs_n_i && we_n_i && ref_n_i && !mode_o[5] && mode_valid_o;
  wire [3:0] rl_x = (mode_o[2:0] == 3'h1) ? 4'h6 : (mode_o[2:0] == 3'h2) ? 4'h8 : 4'h4;
  wire [3:0] bl_x = (mode_o[4:3] == 2'h1) ? 4'h4 : (mode_o[4:3] == 2'h2) ? 4'h8 : 4'h2;
  wire [19:0] am = (burst_length_setting_o == 4'h8) ? 20'h3ffff :
                   (burst_length_setting_o == 4'h4) ? 20'h7ffff : 20'hfffff;
  logic [10:0] dcnt_ff;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) dcnt_ff <= 11'h000;
    else if (!(mode_valid_o && mode_o[7])) dcnt_ff <= 11'h000;
    else if (dcnt_ff != 11'h7ff) dcnt_ff <= dcnt_ff + 11'h001;
  end
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_mode; md |=> mode_valid_o && mode_o == $past(addr_i[17:0]); endproperty
  a_mode: assert property (p_mode) else $error("mode register not captured");
  property p_recov; md |=> mode_set_recovery_o [*6]; endproperty
  a_recov: assert property (p_recov) else $error("recovery status short");
  property p_rl; read_latency_cycles_o == rl_x; endproperty
  a_rl: assert property (p_rl) else $error("read latency wrong");
  property p_wl; write_latency_cycles_o == read_latency_cycles_o + 4'h1; endproperty
  a_wl: assert property (p_wl) else $error("write latency not rl plus one");
  property p_bl; burst_length_setting_o == bl_x; endproperty
  a_bl: assert property (p_bl) else $error("burst length wrong");
  property p_rd; rd |=> read_cmd_o && read_addr_o == ($past(addr_i) & $past(am)); endproperty
  a_rd: assert property (p_rd) else $error("read address not masked");
  property p_ref; rf |=> refresh_o && refresh_bank_o == $past(bank_i); endproperty
  a_ref: assert property (p_ref) else $error("refresh not taken");
  property p_dll; mode_o[7] && dll_locked_o |-> dcnt_ff >= 11'd1020; endproperty
  a_dll: assert property (p_dll) else $error("dll locked early");
  property p_imp; $stable(mode_o) |-> impedance_ext_o == mode_o[8]; endproperty
  a_imp: assert property (p_imp) else $error("impedance source wrong");
  property p_term; mode_valid_o && mode_o[9] && $stable(mode_o) |-> term_input_o; endproperty
  a_term: assert property (p_term) else $error("input termination off");
  property p_trd; read_burst_active_i |=> !term_read_o; endproperty
  a_trd: assert property (p_trd) else $error("read termination on while driving");
endmodule  // sdw_core_props

bind sdw_core sdw_core_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .we_n_i(we_n_i), .ref_n_i(ref_n_i), .addr_i(addr_i), .bank_i(bank_i),
  .read_burst_active_i(read_burst_active_i), .mode_o(mode_o), .mode_valid_o(mode_valid_o),
  .read_latency_cycles_o(read_latency_cycles_o), .write_latency_cycles_o(write_latency_cycles_o),
  .burst_length_setting_o(burst_length_setting_o), .dll_locked_o(dll_locked_o),
  .mode_set_recovery_o(mode_set_recovery_o), .impedance_ext_o(impedance_ext_o),
  .term_read_o(term_read_o), .term_input_o(term_input_o), .refresh_o(refresh_o),
  .refresh_bank_o(refresh_bank_o), .read_cmd_o(read_cmd_o), .read_addr_o(read_addr_o));
`default_nettype wire

/* tb/sdw_dk_model.sv */
// Write data source: drives data clock, data and mask for one burst.
// Assumes the bench pulses go_i once the write window is open.
`default_nettype none
module sdw_dk_model (
  input  wire logic        go_i,
  input  wire logic [3:0]  beats_i,
  input  wire logic [17:0] base_i,
  input  wire logic [7:0]  mask_i,
  output var  logic        dk_o,
  output var  logic [17:0] d_o,
  output var  logic        m_o,
  output var  logic        busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int i;
  initial begin
    dk_o = 1'b0;
    d_o = 18'h3ffff;
    m_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge go_i);
      busy_o = 1'b1;
      for (i = 0; i < beats_i; i++) begin
        d_o = base_i + i[17:0];
        m_o = mask_i[i];
        #31.25;
        dk_o = ~dk_o;
        #31.25;
      end
      // Clock parks low; data stops showing its last word
      d_o = ~d_o;
      m_o = 1'b1;
      busy_o = 1'b0;
    end
  end
endmodule  // sdw_dk_model
`default_nettype wire
